/* design/dsss_defs.svh */
`ifndef DSSS_DEFS_SVH
`define DSSS_DEFS_SVH

// Register word offsets (byte addresses, one 32-bit word each)
`define DSSS_OFF_SELECT       8'h27
`define DSSS_OFF_CONTROL      8'h00
`define DSSS_OFF_STATUS       8'h04

// Control register fields
`define DSSS_CTL_WSEL_LSB     0
`define DSSS_CTL_ARM_BIT      4

// Window select encodings
`define DSSS_WSEL_STATE2      2'h1
`define DSSS_WSEL_STATE3      2'h2
`define DSSS_WSEL_FLAGS       2'h3

// Reset values
`define DSSS_SEL_RESET        4'h0
`define DSSS_FLAG_RESET       4'h0

`endif

/* design/dsss_pkg.sv */
package dsss_pkg;

   // Sequencer state as seen by this block
   typedef enum logic [1:0] {
      DSSS_ST1,
      DSSS_ST2,
      DSSS_ST3,
      DSSS_FINAL
   } dsss_state_t;

   // Outcome of evaluating a match vector against a code
   typedef struct packed {
      logic        go;
      dsss_state_t dest;
   } dsss_move_t;

endpackage

/* design/dsss_select.sv */
`timescale 1ns/1ps
`include "dsss_defs.svh"
module dsss_select #(
   parameter int NCH = 4
) (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   // Avalon-MM slave
   input  wire logic [7:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   // Sequencer side
   input  wire logic [NCH-1:0]        match_in,
   input  wire dsss_pkg::dsss_state_t cur_state,
   output logic                       next_valid,
   output dsss_pkg::dsss_state_t      next_state,
   output logic [1:0]                 window_select,
   output logic                       armed
);
   import dsss_pkg::*;

   // State held by this block
   logic             rst_meta_q;
   logic             rst_sync_q;
   logic [3:0]       s2_code_q;
   logic [3:0]       s3_code_q;
   logic [NCH-1:0]   flags_q;
   logic [1:0]       wsel_q;
   logic             arm_q;
   logic             ack_q;
   logic [31:0]      rdata_q;
   logic             nv_q;
   dsss_state_t      ns_q;

   // Reset release through two flops; assertion stays asynchronous
   // A release that lands near a clock edge can only upset the first flop
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   // Everything below resets from this synchronised copy
   wire rst_n = rst_sync_q;

   // Bus decode; every access takes exactly one wait cycle
   // Map: control at the low word (window in bits 1:0, arm in bit 4), status
   // holds the flags, and the shared select address shows one of three bytes.
   // Only byte lane 0 carries anything, so a write without it is dropped.
   // Reads have no side effects, so a repeated read is always harmless.
   wire       req      = avs_read | avs_write;
   wire       take     = req & ack_q;
   wire       hit_sel  = avs_address == `DSSS_OFF_SELECT;
   wire       hit_ctl  = avs_address == `DSSS_OFF_CONTROL;
   wire       hit_sts  = avs_address == `DSSS_OFF_STATUS;
   wire       wr_lane0 = take & avs_write & avs_byteenable[0];
   wire       wr_ctl   = wr_lane0 & hit_ctl;
   wire       arm_set  = wr_ctl & avs_writedata[`DSSS_CTL_ARM_BIT];
   // Locked while armed so a session never sees its code change
   wire       wr_s2    = wr_lane0 & hit_sel & (wsel_q == `DSSS_WSEL_STATE2) & ~arm_q;
   wire       wr_s3    = wr_lane0 & hit_sel & (wsel_q == `DSSS_WSEL_STATE3) & ~arm_q;
   assign avs_waitrequest = req & ~ack_q;

   // Overlaid register read mux; flags writes fall through to nothing
   logic [7:0] sel_view;
   always_comb begin
      unique case (wsel_q)
         `DSSS_WSEL_STATE2: sel_view = {4'h0, s2_code_q};
         `DSSS_WSEL_STATE3: sel_view = {4'h0, s3_code_q};
         `DSSS_WSEL_FLAGS:  sel_view = {4'h0, flags_q};
         default:           sel_view = 8'h00;             // State1 register lives elsewhere
      endcase
   end
   // Control reads back the arm bit and the window; unmapped addresses read zero
   wire [31:0] ctl_view = {27'h0, arm_q, 2'h0, wsel_q};
   wire [31:0] sts_view = {28'h0, flags_q};
   wire [31:0] rd_mux   = hit_sel ? {24'h0, sel_view} :
                          hit_ctl ? ctl_view :
                          hit_sts ? sts_view : 32'h0;

   // Handshake and read data
   // Read data is latched every cycle, so it is settled by the edge at which
   // waitrequest drops; the extra wait cycle is the price of a registered bus
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ack_q   <= req & ~ack_q;
         rdata_q <= rd_mux;
      end
   end
   assign avs_readdata = rdata_q;

   // Control and code registers
   // A final-state result disarms unless control is written in the same cycle, so software sees the session end in the arm bit
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wsel_q    <= 2'h0;
         arm_q     <= 1'b0;
         s2_code_q <= `DSSS_SEL_RESET;
         s3_code_q <= `DSSS_SEL_RESET;
      end else begin
         if (wr_ctl) begin
            wsel_q <= avs_writedata[`DSSS_CTL_WSEL_LSB +: 2];
            arm_q  <= avs_writedata[`DSSS_CTL_ARM_BIT];
         end else if (nv_q && ns_q == DSSS_FINAL) begin
            arm_q <= 1'b0; // Session ends at final state
         end
         if (wr_s2)
            s2_code_q <= avs_writedata[3:0];
         if (wr_s3)
            s3_code_q <= avs_writedata[3:0];
      end
   end

   // Sticky flags; arming clears, a match in the arm cycle counts only if already armed
   // Flags only set while armed, so stray matches between sessions leave them alone
   // Matches only arrive from comparators software has enabled
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_flag
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n)
               flags_q[g] <= 1'b0;
            else if (arm_q && match_in[g])
               flags_q[g] <= 1'b1;
            else if (arm_set)
               flags_q[g] <= 1'b0;
         end
      end
   endgenerate

   // Per-channel destination lookup; go=0 means that channel is ignored
   // Each channel sees the same code but learns only its own destination, so
   // the priority stage below can treat every channel alike
   function automatic dsss_move_t lookup(input logic s3, input logic [3:0] c, input int ch);
      dsss_move_t m;
      m.go   = 1'b0;
      m.dest = DSSS_ST1;
      if (!s3) begin
         // While in State2
         unique case (c)
            // Any match to State1
            4'h0: begin
               m.go   = 1'h1;
               m.dest = DSSS_ST1;
            end
            // Any match to State3
            4'h1: begin
               m.go   = 1'h1;
               m.dest = DSSS_ST3;
            end
            // Any match to the final state
            4'h2: begin
               m.go   = 1'h1;
               m.dest = DSSS_FINAL;
            end
            // Only channel 3, to State1
            4'h3: begin
               m.go   = (ch == 3);
               m.dest = DSSS_ST1;
            end
            // Only channel 3, to State3
            4'h4: begin
               m.go   = (ch == 3);
               m.dest = DSSS_ST3;
            end
            // Only channel 3, to the final state
            4'h5: begin
               m.go   = (ch == 3);
               m.dest = DSSS_FINAL;
            end
            // Channel 0 to State1, channel 1 to State3
            4'h6: begin
               m.go   = (ch == 0) || (ch == 1);
               m.dest = (ch == 0) ? DSSS_ST1 : DSSS_ST3;
            end
            // Channel 0 to final, channel 1 to State3
            4'h7: begin
               m.go   = (ch == 0) || (ch == 1);
               m.dest = (ch == 0) ? DSSS_FINAL : DSSS_ST3;
            end
            // Channel 0 to State1, channel 2 to State3
            4'h8: begin
               m.go   = (ch == 0) || (ch == 2);
               m.dest = (ch == 0) ? DSSS_ST1 : DSSS_ST3;
            end
            // Channel 0 to final, channel 2 to State3
            4'h9: begin
               m.go   = (ch == 0) || (ch == 2);
               m.dest = (ch == 0) ? DSSS_FINAL : DSSS_ST3;
            end
            // Channel 1 to State1, channel 3 to State3
            4'hA: begin
               m.go   = (ch == 1) || (ch == 3);
               m.dest = (ch == 1) ? DSSS_ST1 : DSSS_ST3;
            end
            // Channel 1 to final, channel 3 to State3
            4'hB: begin
               m.go   = (ch == 1) || (ch == 3);
               m.dest = (ch == 1) ? DSSS_FINAL : DSSS_ST3;
            end
            // Channel 2 to State1, channel 3 to final
            4'hC: begin
               m.go   = (ch == 2) || (ch == 3);
               m.dest = (ch == 2) ? DSSS_ST1 : DSSS_FINAL;
            end
            // Every channel but 2 to final
            4'hD: begin
               m.go   = (ch != 2);
               m.dest = DSSS_FINAL;
            end
            // Reserved codes hold the sequencer where it is
            4'hE, 4'hF: m.go = 1'h0;
         endcase
      end else begin
         // While in State3
         unique case (c)
            // Any match to State1
            4'h0: begin
               m.go   = 1'h1;
               m.dest = DSSS_ST1;
            end
            // Any match to State2
            4'h1: begin
               m.go   = 1'h1;
               m.dest = DSSS_ST2;
            end
            // Any match to the final state
            4'h2: begin
               m.go   = 1'h1;
               m.dest = DSSS_FINAL;
            end
            // Only channel 0, to State1
            4'h3: begin
               m.go   = (ch == 0);
               m.dest = DSSS_ST1;
            end
            // Only channel 0, to State2
            4'h4: begin
               m.go   = (ch == 0);
               m.dest = DSSS_ST2;
            end
            // Channel 0 to final, channel 1 to State1
            4'h5: begin
               m.go   = (ch == 0) || (ch == 1);
               m.dest = (ch == 0) ? DSSS_FINAL : DSSS_ST1;
            end
            // Only channel 1, to State1
            4'h6: begin
               m.go   = (ch == 1);
               m.dest = DSSS_ST1;
            end
            // Only channel 1, to State2
            4'h7: begin
               m.go   = (ch == 1);
               m.dest = DSSS_ST2;
            end
            // Only channel 1, to the final state
            4'h8: begin
               m.go   = (ch == 1);
               m.dest = DSSS_FINAL;
            end
            // Channel 0 to final, channel 2 to State2
            4'h9: begin
               m.go   = (ch == 0) || (ch == 2);
               m.dest = (ch == 0) ? DSSS_FINAL : DSSS_ST2;
            end
            // Channel 1 to State1, channel 3 to State2
            4'hA: begin
               m.go   = (ch == 1) || (ch == 3);
               m.dest = (ch == 1) ? DSSS_ST1 : DSSS_ST2;
            end
            // Channel 1 to final, channel 3 to State2
            4'hB: begin
               m.go   = (ch == 1) || (ch == 3);
               m.dest = (ch == 1) ? DSSS_FINAL : DSSS_ST2;
            end
            // Only channel 2, to the final state
            4'hC: begin
               m.go   = (ch == 2);
               m.dest = DSSS_FINAL;
            end
            // Only channel 3, to the final state
            4'hD: begin
               m.go   = (ch == 3);
               m.dest = DSSS_FINAL;
            end
            // Reserved codes hold the sequencer where it is
            4'hE, 4'hF: m.go = 1'h0;
         endcase
      end
      return m;
   endfunction

   // Evaluate every channel in parallel
   // The code follows the current state; outside State2 and State3 nothing moves
   wire        in_s2 = cur_state == DSSS_ST2;
   wire        in_s3 = cur_state == DSSS_ST3;
   wire [3:0]  code  = in_s3 ? s3_code_q : s2_code_q;
   dsss_move_t mv [NCH];
   generate
      for (g = 0; g < NCH; g++) begin : g_eval
         assign mv[g] = lookup(in_s3, code, g);
      end
   endgenerate

   // Priority: any qualifying final wins, else lowest channel
   // The scan runs from high to low so the lowest channel writes last;
   // final is forced afterwards, so a lower channel can never mask it
   dsss_move_t pick;
   always_comb begin
      pick.go   = 1'b0;
      pick.dest = DSSS_ST1;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (match_in[i] && mv[i].go)
            pick = mv[i];
      end
      for (int i = 0; i < NCH; i++) begin
         if (match_in[i] && mv[i].go && mv[i].dest == DSSS_FINAL)
            pick.dest = DSSS_FINAL;
      end
   end

   // Registered next-state result, valid one cycle after the match
   // next_state reloads every cycle, even while next_valid is low; only the pulse counts
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         nv_q <= 1'b0;
         ns_q <= DSSS_ST1;
      end else begin
         nv_q <= arm_q & (in_s2 | in_s3) & pick.go;
         ns_q <= pick.dest;
      end
   end

   // Results and status toward the sequencer and the host
   assign next_valid    = nv_q;
   assign next_state    = ns_q;
   assign window_select = wsel_q;
   assign armed         = arm_q;
endmodule

/* verification/dsss_match_src.sv */
`timescale 1ns/1ps
module dsss_match_src (
   // Comparator enables and raw hits
   input  wire logic [3:0] en,
   input  wire logic [3:0] hit,
   // Match channels toward the block
   output logic      [3:0] match_in
);
   // A comparator that software has not enabled never reports a match
   assign match_in = en & hit;
endmodule

/* verification/dsss_select_checker.sv */
`timescale 1ns/1ps
`include "dsss_defs.svh"
module dsss_select_checker #(
   parameter int NCH = 4
) (
   // Clock, reset and bus
   input wire logic                  clk_sys,
   input wire logic                  resetn,
   input wire logic [7:0]            avs_address,
   input wire logic                  avs_read,
   input wire logic                  avs_write,
   input wire logic [31:0]           avs_writedata,
   input wire logic [3:0]            avs_byteenable,
   input wire logic [31:0]           avs_readdata,
   input wire logic                  avs_waitrequest,
   // Sequencer side
   input wire logic [NCH-1:0]        match_in,
   input wire dsss_pkg::dsss_state_t cur_state,
   input wire logic                  next_valid,
   input wire dsss_pkg::dsss_state_t next_state,
   input wire logic [1:0]            window_select,
   input wire logic                  armed
);
   import dsss_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Accepted accesses, and the code in force for the current state
   wire       acc    = !avs_waitrequest && (avs_write ? avs_byteenable[0] : avs_read);
   wire       sel_wr = acc && avs_write && !armed && avs_address == `DSSS_OFF_SELECT;
   wire       sel_rd = acc && avs_read && avs_address == `DSSS_OFF_SELECT;
   wire       ctl_wr = acc && avs_write && avs_address == `DSSS_OFF_CONTROL;
   wire       act    = armed && (|match_in) && (cur_state == DSSS_ST2 || cur_state == DSSS_ST3);
   logic [3:0] c2_q, c3_q;
   wire [3:0] code   = (cur_state == DSSS_ST2) ? c2_q : c3_q;
   // Shadow codes: a refused write must not move them, so refusals show up in readback
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         c2_q <= 4'h0;
         c3_q <= 4'h0;
      end else if (sel_wr && window_select == `DSSS_WSEL_STATE2) begin
         c2_q <= avs_writedata[3:0];
      end else if (sel_wr && window_select == `DSSS_WSEL_STATE3) begin
         c3_q <= avs_writedata[3:0];
      end
   end
   a_wait_once: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("wait state count wrong");
   a_upper_zero: assert property (sel_rd |-> avs_readdata[31:4] == 28'h0)
      else $error("upper bits not zero");
   a_hidden_zero: assert property (sel_rd && window_select == 2'h0 |-> avs_readdata == 32'h0)
      else $error("window 00 not zero");
   a_code2_read: assert property (sel_rd && window_select == `DSSS_WSEL_STATE2 |-> avs_readdata[3:0] == c2_q)
      else $error("state2 code readback wrong");
   a_code3_read: assert property (sel_rd && window_select == `DSSS_WSEL_STATE3 |-> avs_readdata[3:0] == c3_q)
      else $error("state3 code readback wrong");
   a_window_load: assert property (ctl_wr |=> window_select == $past(avs_writedata[1:0]))
      else $error("window select not loaded");
   a_reserved_idle: assert property (act && code[3:1] == 3'h7 |=> !next_valid)
      else $error("reserved code moved");
   a_any_final: assert property (act && code == 4'h2 |=> next_valid && next_state == DSSS_FINAL)
      else $error("any match not final");
   a_quiet_idle: assert property (!armed || match_in == '0 |=> !next_valid)
      else $error("move without cause");
   c_final: cover property (next_valid && next_state == DSSS_FINAL);
   c_flags_read: cover property (sel_rd && window_select == `DSSS_WSEL_FLAGS);
   c_reserved: cover property (act && code == 4'hF);
endmodule
bind dsss_select dsss_select_checker #(.NCH(NCH)) chk (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .match_in, .cur_state, .next_valid,
   .next_state, .window_select, .armed);

/* verification/tb_dsss_select.sv */
`timescale 1ns/1ps
module tb_dsss_select;
   import dsss_pkg::*;
   logic        clk_sys, resetn, avs_read, avs_write, avs_waitrequest, next_valid, armed;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable, match_in, en, hit;
   logic [1:0]  window_select;
   dsss_state_t cur_state, next_state;
   int          n_fail, comparisons;
   // Destination per channel, nibble c for channel c: 0 none, 1..3 state, 4 final
   localparam logic [15:0] DST [2][16] = '{
      '{16'h1111, 16'h3333, 16'h4444, 16'h1000, 16'h3000, 16'h4000, 16'h0031, 16'h0034,
        16'h0301, 16'h0304, 16'h3010, 16'h3040, 16'h4100, 16'h4044, 16'h0000, 16'h0000},
      '{16'h1111, 16'h2222, 16'h4444, 16'h0001, 16'h0002, 16'h0014, 16'h0010, 16'h0020,
        16'h0040, 16'h0204, 16'h2010, 16'h2040, 16'h0400, 16'h4000, 16'h0000, 16'h0000}};
   dsss_select #(.NCH(4)) uut (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .match_in, .cur_state, .next_valid, .next_state,
      .window_select, .armed);
   dsss_match_src src (.en, .hit, .match_in);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic test_done;
      $display("fails %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus cycle, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_sys);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   // One-cycle hit; the result is registered, so it is looked at two edges later
   task automatic pulse(input dsss_state_t st, input logic [3:0] v);
      @(posedge clk_sys);
      cur_state <= st;
      hit <= v;
      @(posedge clk_sys);
      hit <= 4'h0;
      @(posedge clk_sys);
   endtask
   // Final beats everything, otherwise the lowest moving channel wins
   function automatic logic [2:0] want(input logic [15:0] row, input logic [3:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int c = 3; c >= 0; c--) if (v[c] && row[4*c +: 3] != 3'h0) r = row[4*c +: 3];
      for (int c = 0; c < 4; c++) if (v[c] && row[4*c +: 3] == 3'h4) r = 3'h4;
      return r;
   endfunction
   task automatic t_regs;
      rd(8'h27, 8'h00);
      wr(8'h00, 8'h01);
      rd(8'h27, 8'h00);
      chk({6'h0, window_select}, 8'h01);
      wr(8'h27, 8'hFF);
      rd(8'h27, 8'h0F);
      wr(8'h00, 8'h02);
      rd(8'h27, 8'h00);
      wr(8'h27, 8'hA6);
      rd(8'h27, 8'h06);
      wr(8'h00, 8'h11);
      wr(8'h27, 8'h03);
      rd(8'h27, 8'h0F);
      chk({7'h0, armed}, 8'h01);
      rd(8'h00, 8'h11);
      wr(8'h00, 8'h12);
      wr(8'h27, 8'h01);
      rd(8'h27, 8'h06);
      wr(8'h00, 8'h00);
      wr(8'h27, 8'h05);
      rd(8'h27, 8'h00);
      wr(8'h00, 8'h01);
      rd(8'h27, 8'h0F);
      wr(8'h00, 8'h02);
      rd(8'h27, 8'h06);
      rd(8'h40, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_table;
      logic [2:0] e;
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 16; c++) begin
            wr(8'h00, s ? 8'h02 : 8'h01);
            wr(8'h27, 8'(c));
            for (int v = 1; v < 16; v++) begin
               e = want(DST[s][c], 4'(v));
               wr(8'h00, s ? 8'h12 : 8'h11);
               pulse(s ? DSSS_ST3 : DSSS_ST2, 4'(v));
               chk({7'h0, next_valid}, {7'h0, e != 3'h0});
               if (e != 3'h0) chk({6'h0, next_state}, {5'h0, e - 3'h1});
               @(posedge clk_sys);
               chk({7'h0, armed}, {7'h0, e != 3'h4});
            end
         end
      end
      $display("t_table done");
   endtask
   task automatic t_flags;
      wr(8'h00, 8'h13);
      rd(8'h27, 8'h00);
      pulse(DSSS_ST1, 4'h2);
      rd(8'h27, 8'h02);
      en <= 4'h7;
      pulse(DSSS_ST1, 4'h8);
      en <= 4'hF;
      rd(8'h27, 8'h02);
      pulse(DSSS_ST1, 4'hA);
      rd(8'h27, 8'h0A);
      wr(8'h00, 8'h03);
      wr(8'h27, 8'hFF);
      rd(8'h27, 8'h0A);
      rd(8'h04, 8'h0A);
      wr(8'h00, 8'h13);
      rd(8'h27, 8'h00);
      $display("t_flags done");
   endtask
   initial begin
      resetn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      cur_state = DSSS_ST1;
      hit = 4'h0;
      en = 4'hF;
      n_fail = 0;
      comparisons = 0;
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_regs;
      t_table;
      t_flags;
      test_done;
   end
   // Watchdog: the whole run needs well under 10000 cycles
   initial begin
      #300000;
      n_fail++;
      test_done;
   end
endmodule
